// File: src/ptimer_regs.vh
// register map, field positions and reset values for the periodic timer
`ifndef PTIMER_REGS_VH
`define PTIMER_REGS_VH

// register byte offsets
`define PT_CTRL_A_OFF   6'h00
`define PT_CTRL_B_OFF   6'h04
`define PT_COUNT_OFF    6'h08
`define PT_CMPA_OFF     6'h0C
`define PT_PERIOD_OFF   6'h10
`define PT_FLAGS_OFF    6'h14

// control a fields
`define PT_RUN_BIT      0
`define PT_TICK_DIV_LSB 8
`define PT_TICK_DIV_MSB 15

// control b fields (timer_control_reg_b)
`define PT_MODE_MSB     7
`define PT_MODE_LSB     6
`define PT_IO_MSB       5
`define PT_IO_LSB       4
`define PT_OC_BIT       3
`define PT_POL_BIT      2
`define PT_CKS_BIT      1
`define PT_CCLR_BIT     0

// flag bits
`define PT_FLAG_A_BIT   0
`define PT_FLAG_P_BIT   1

// modes
`define PT_MODE_CMP     2'h0
`define PT_MODE_CAP     2'h1
`define PT_MODE_PWM     2'h2
`define PT_MODE_TMR     2'h3

// output actions
`define PT_IO_NONE      2'h0
`define PT_IO_LOW       2'h1
`define PT_IO_HIGH      2'h2
`define PT_IO_TOGGLE    2'h3

// reset values
`define PT_CTRL_A_RST   32'h0000_0000
`define PT_CTRL_B_RST   8'h00
`define PT_CNT_MAX      10'h3FF

// axi responses
`define PT_RESP_OKAY    2'h0
`define PT_RESP_SLVERR  2'h2

`endif

// File: src/periodic_timer_modes.v
// periodic capture/compare timer with an axi4-lite register slave
`timescale 1ns/1ps
`include "ptimer_regs.vh"

module periodic_timer_modes #(
   parameter CW = 10
) (
   // clock and reset
   input  wire          i_mclk,
   input  wire          i_arst_n,
   // axi4-lite write address
   input  wire [5:0]    i_awaddr,
   input  wire          i_awvalid,
   output wire          o_awready,
   // axi4-lite write data
   input  wire [31:0]   i_wdata,
   input  wire [3:0]    i_wstrb,
   input  wire          i_wvalid,
   output wire          o_wready,
   // axi4-lite write response
   output reg  [1:0]    o_bresp,
   output reg           o_bvalid,
   input  wire          i_bready,
   // axi4-lite read address
   input  wire [5:0]    i_araddr,
   input  wire          i_arvalid,
   output wire          o_arready,
   // axi4-lite read data
   output reg  [31:0]   o_rdata,
   output reg  [1:0]    o_rresp,
   output reg           o_rvalid,
   input  wire          i_rready,
   // timer pins
   input  wire          i_capture_input_pin,
   input  wire          i_ext_trigger_pin,
   output reg           o_timer_out,
   output reg           o_timer_out_en,
   // match flags toward the interrupt controller
   output reg           o_match_a_flag,
   output reg           o_match_p_flag
);

   // ====================================================================
   // register state
   reg             counter_run;
   reg  [7:0]      tick_div;
   reg  [7:0]      timer_control_reg_b;
   reg  [CW-1:0]   count;
   reg  [CW-1:0]   compare_a_value;
   reg  [CW-1:0]   period_compare_value;
   reg  [7:0]      tick_cnt;
   reg             run_d;
   reg             cap_d;
   reg             trg_d;
   reg             cmp_level;
   reg  [5:0]      aw_addr;
   reg             aw_held;
   reg  [31:0]     w_data;
   reg  [3:0]      w_strb;
   reg             w_held;

   // ====================================================================
   // field decode
   wire [1:0] operating_mode_select = timer_control_reg_b[`PT_MODE_MSB:`PT_MODE_LSB];
   wire [1:0] output_action_select  = timer_control_reg_b[`PT_IO_MSB:`PT_IO_LSB];
   wire       output_initial_level  = timer_control_reg_b[`PT_OC_BIT];
   wire       output_invert         = timer_control_reg_b[`PT_POL_BIT];
   wire       capture_source_select = timer_control_reg_b[`PT_CKS_BIT];
   wire       counter_clear_select  = timer_control_reg_b[`PT_CCLR_BIT];

   wire mode_cmp  = (operating_mode_select == `PT_MODE_CMP) ||
                    (operating_mode_select == `PT_MODE_TMR);
   wire mode_cap  = (operating_mode_select == `PT_MODE_CAP);
   wire mode_pwm  = (operating_mode_select == `PT_MODE_PWM) &&
                    (output_action_select != `PT_IO_TOGGLE);
   wire mode_sp   = (operating_mode_select == `PT_MODE_PWM) &&
                    (output_action_select == `PT_IO_TOGGLE);

   // ====================================================================
   // timer clock tick: one tick every tick_div+1 system clocks
   // the divider restarts while stopped, so a new run gets its first tick tick_div+1 clocks after it starts
   wire tick = (tick_cnt == tick_div);

   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tick_cnt <= 8'h00;
      end else if (!counter_run || tick) begin
         tick_cnt <= 8'h00;
      end else begin
         tick_cnt <= tick_cnt + 8'h01;
      end
   end

   // ====================================================================
   // comparators; the next count equal to the period or to a nonzero compare A value marks a match
   wire [CW-1:0] count_inc = count + {{(CW-1){1'b0}}, 1'b1};
   wire          overflow  = (count == {CW{1'b1}});
   wire          hit_a     = tick && counter_run && (compare_a_value != {CW{1'b0}})
                             && (count_inc == compare_a_value);
   wire          hit_p_raw = tick && counter_run && (count_inc == period_compare_value);
   // zero period lets the counter wrap: period of 1024 counts
   wire          hit_p     = (period_compare_value == {CW{1'b0}}) ?
                             (tick && counter_run && overflow) : hit_p_raw;

   // ====================================================================
   // edge detection on run and the input pins
   wire run_rise  = counter_run && !run_d;
   wire cap_src   = capture_source_select ? i_ext_trigger_pin : i_capture_input_pin;
   wire cap_prev  = capture_source_select ? trg_d : cap_d;
   wire cap_rise  = cap_src && !cap_prev;
   wire cap_fall  = !cap_src && cap_prev;
   // action 00 rising, 01 falling, 10 both, 11 off
   reg  cap_hit;
   always @* begin
      case (output_action_select)
         `PT_IO_NONE : cap_hit = cap_rise;
         `PT_IO_LOW  : cap_hit = cap_fall;
         `PT_IO_HIGH : cap_hit = cap_rise || cap_fall;
         default     : cap_hit = 1'b0;
      endcase
   end
   wire capture   = mode_cap && counter_run && cap_hit;
   wire trig_edge = mode_sp && i_ext_trigger_pin && !trg_d;

   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         run_d <= 1'b0;
         cap_d <= 1'b0;
         trg_d <= 1'b0;
      end else begin
         run_d <= counter_run;
         cap_d <= i_capture_input_pin;
         trg_d <= i_ext_trigger_pin;
      end
   end

   // ====================================================================
   // counter
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count <= {CW{1'b0}};
      end else if (run_rise) begin
         count <= {CW{1'b0}};
      end else if (tick && counter_run) begin
         if (mode_sp) begin
            count <= count_inc;
         end else if (mode_cmp && counter_clear_select) begin
            count <= hit_a ? {CW{1'b0}} : count_inc;
         end else begin
            count <= hit_p ? {CW{1'b0}} : count_inc;
         end
      end
   end

   // ====================================================================
   // match flags, one-cycle pulses
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_match_a_flag <= 1'b0;
         o_match_p_flag <= 1'b0;
      end else begin
         o_match_a_flag <= mode_cap ? capture : hit_a;
         o_match_p_flag <= mode_sp ? 1'b0 :
                           (mode_cmp && counter_clear_select) ? 1'b0 : hit_p;
      end
   end

   // ====================================================================
   // compare-match output level
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cmp_level <= 1'b0;
      end else if (run_rise) begin
         cmp_level <= output_initial_level;
      end else if (mode_cmp && hit_a) begin
         case (output_action_select)
            `PT_IO_LOW    : cmp_level <= 1'b0;
            `PT_IO_HIGH   : cmp_level <= 1'b1;
            `PT_IO_TOGGLE : cmp_level <= !cmp_level;
            default       : cmp_level <= cmp_level;
         endcase
      end
   end

   // pwm: active while count below duty; duty at or above period stays active
   // the duty compare is combinational, so a new duty shows within one clock
   wire [CW:0] period_full = (period_compare_value == {CW{1'b0}}) ?
                             {1'b1, {CW{1'b0}}} : {1'b0, period_compare_value};
   wire pwm_act = ({1'b0, compare_a_value} >= period_full) ||
                  (count < compare_a_value);
   reg  pwm_pin;
   always @* begin
      case (output_action_select)
         `PT_IO_NONE : pwm_pin = 1'b0;
         `PT_IO_LOW  : pwm_pin = 1'b1;
         default     : pwm_pin = (counter_run && pwm_act) ? output_initial_level
                                                           : !output_initial_level;
      endcase
   end

   // ====================================================================
   // output pin register; inversion acts in every mode, capture included
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_timer_out    <= 1'b0;
         o_timer_out_en <= 1'b0;
      end else begin
         o_timer_out_en <= (operating_mode_select == `PT_MODE_CMP) ||
                           (operating_mode_select == `PT_MODE_PWM);
         if (mode_pwm) begin
            o_timer_out <= pwm_pin ^ output_invert;
         end else if (mode_sp) begin
            // pulse stands while run is high
            o_timer_out <= (counter_run && !hit_a) ^ output_invert;
         end else begin
            o_timer_out <= cmp_level ^ output_invert;
         end
      end
   end

   // ====================================================================
   // axi4-lite handshakes: address and data held until both present
   assign o_awready = !aw_held;
   assign o_wready  = !w_held;
   assign o_arready = !o_rvalid;
   wire   do_write  = aw_held && w_held && !o_bvalid;
   // a write to an unmapped word changes nothing and is answered with slverr
   wire   wr_ok     = (aw_addr == `PT_CTRL_A_OFF) || (aw_addr == `PT_CTRL_B_OFF) ||
                      (aw_addr == `PT_COUNT_OFF)  || (aw_addr == `PT_CMPA_OFF)  ||
                      (aw_addr == `PT_PERIOD_OFF) || (aw_addr == `PT_FLAGS_OFF);
   wire   wr_ctrl_a = do_write && (aw_addr == `PT_CTRL_A_OFF);

   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         aw_held  <= 1'b0;
         aw_addr  <= 6'h00;
         w_held   <= 1'b0;
         w_data   <= 32'h0000_0000;
         w_strb   <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp  <= `PT_RESP_OKAY;
      end else begin
         if (i_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= {i_awaddr[5:2], 2'b00};
         end
         if (i_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
         if (do_write) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp  <= wr_ok ? `PT_RESP_OKAY : `PT_RESP_SLVERR;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // ====================================================================
   // writable registers; hardware set/clear of run beats the software write
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         // the run bit and tick_div of the all-zero control a reset word are stored here
         counter_run          <= 1'b0;
         tick_div             <= 8'h00;
         timer_control_reg_b  <= `PT_CTRL_B_RST;
         compare_a_value      <= {CW{1'b0}};
         period_compare_value <= {CW{1'b0}};
      end else begin
         if (wr_ctrl_a && w_strb[0]) begin
            counter_run <= w_data[`PT_RUN_BIT];
         end
         if (wr_ctrl_a && w_strb[1]) begin
            tick_div <= w_data[`PT_TICK_DIV_MSB:`PT_TICK_DIV_LSB];
         end
         if (trig_edge) begin
            counter_run <= 1'b1;
         end else if (mode_sp && hit_a) begin
            counter_run <= 1'b0;
         end
         if (do_write && (aw_addr == `PT_CTRL_B_OFF) && w_strb[0]) begin
            timer_control_reg_b <= w_data[7:0];
         end
         if (capture) begin
            compare_a_value <= count;
         end else if (do_write && (aw_addr == `PT_CMPA_OFF)) begin
            compare_a_value <= wmerge(compare_a_value, w_data, w_strb);
         end
         if (do_write && (aw_addr == `PT_PERIOD_OFF)) begin
            period_compare_value <= wmerge(period_compare_value, w_data, w_strb);
         end
      end
   end

   // byte-lane merge of a 10-bit value
   function [CW-1:0] wmerge;
      input [CW-1:0] old;
      input [31:0]   d;
      input [3:0]    s;
      reg   [15:0]   t;
      begin
         t = {{(16-CW){1'b0}}, old};
         if (s[0]) t[7:0]  = d[7:0];
         if (s[1]) t[15:8] = d[15:8];
         wmerge = t[CW-1:0];
      end
   endfunction

   // ====================================================================
   // read path
   // reads have no side effects; the flags word shows only this cycle's pulses
   reg [31:0] rd_mux;
   reg        rd_ok;
   always @* begin
      rd_ok = 1'b1;
      case ({i_araddr[5:2], 2'b00})
         `PT_CTRL_A_OFF : rd_mux = {16'h0000, tick_div, 7'h00, counter_run};
         `PT_CTRL_B_OFF : rd_mux = {24'h000000, timer_control_reg_b};
         `PT_COUNT_OFF  : rd_mux = {{(32-CW){1'b0}}, count};
         `PT_CMPA_OFF   : rd_mux = {{(32-CW){1'b0}}, compare_a_value};
         `PT_PERIOD_OFF : rd_mux = {{(32-CW){1'b0}}, period_compare_value};
         `PT_FLAGS_OFF  : rd_mux = {30'h00000000, o_match_p_flag, o_match_a_flag};
         default : begin
            rd_mux = 32'h0000_0000;
            rd_ok  = 1'b0;
         end
      endcase
   end

   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rvalid <= 1'b0;
         o_rdata  <= 32'h0000_0000;
         o_rresp  <= `PT_RESP_OKAY;
      end else if (i_arvalid && !o_rvalid) begin
         o_rvalid <= 1'b1;
         o_rdata  <= rd_mux;
         o_rresp  <= rd_ok ? `PT_RESP_OKAY : `PT_RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

endmodule // periodic_timer_modes

// File: tb/ext_pin_model.sv
// stimulus model of the circuitry driving the timer input pins
`timescale 1ns/1ps
module ext_pin_model (
   // clock
   input  wire i_mclk,
   // pins toward the timer
   output reg  o_cap,
   output reg  o_trig
);
   initial begin
      o_cap  = 1'b0;
      o_trig = 1'b0;
   end
   // one pulse of w clocks on the chosen pin, changed just after an edge
   task pulse(input sel, input integer w);
      begin
         if (sel) o_trig <= 1'b1;
         else o_cap <= 1'b1;
         repeat (w) @(posedge i_mclk);
         o_trig <= 1'b0;
         o_cap  <= 1'b0;
      end
   endtask
   // two pulses whose rising edges are d clocks apart
   task two(input sel, input integer w, input integer d);
      begin
         pulse(sel, w);
         repeat (d - w) @(posedge i_mclk);
         pulse(sel, w);
      end
   endtask
endmodule // ext_pin_model

// File: tb/periodic_timer_modes_checker.sv
// port-level assertions for the periodic timer
`timescale 1ns/1ps
module periodic_timer_modes_checker #(
   parameter CW = 10
) (
   // clock, reset and bus
   input wire        i_mclk,
   input wire        i_arst_n,
   input wire [5:0]  i_awaddr,
   input wire        i_awvalid,
   input wire        o_awready,
   input wire [31:0] i_wdata,
   input wire        i_wvalid,
   input wire        o_wready,
   input wire [1:0]  o_bresp,
   input wire        o_bvalid,
   input wire        i_bready,
   input wire        i_arvalid,
   input wire        o_arready,
   input wire [31:0] o_rdata,
   input wire        o_rvalid,
   input wire        i_rready,
   // timer side
   input wire        o_timer_out_en,
   input wire        o_match_a_flag,
   input wire        o_match_p_flag
);
   // ==========
   // shadow of control b; quiet masks the settling after any write
   wire       wr = i_awvalid && o_awready && i_wvalid && o_wready;
   reg  [7:0] ctl;
   reg  [3:0] quiet;
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctl   <= 8'h00;
         quiet <= 4'h0;
      end else begin
         if (wr && i_awaddr[5:2] == 4'h1) ctl <= i_wdata[7:0];
         if (wr) quiet <= 4'h0;
         else if (quiet != 4'hF) quiet <= quiet + 4'h1;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   // ==========
   // assertions
   // both halves are registered first, so the answer stands two edges after the take
   a_write_answer: assert property (wr |-> ##2 o_bvalid)
      else $error("write not answered");
   a_write_resp: assert property (wr |-> ##2
      o_bresp == ($past(i_awaddr, 2) > 6'h17 ? 2'h2 : 2'h0))
      else $error("bad write response code");
   a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read not answered");
   a_b_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   a_r_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped");
   a_ar_refused: assert property (o_rvalid |-> !o_arready)
      else $error("read address taken while busy");
   a_pin_release: assert property (quiet > 4'h3 |-> o_timer_out_en == !ctl[6])
      else $error("pin enable wrong for mode");
   a_no_p_flag: assert property (quiet > 4'h3 && ctl[7:6] == 2'h0 && ctl[0] |-> !o_match_p_flag)
      else $error("period flag under A clear");
   a_flag_pulse: assert property (o_match_a_flag |=> !o_match_a_flag)
      else $error("A flag longer than one cycle");
endmodule // periodic_timer_modes_checker

// File: tb/tb_periodic_timer_modes.sv
// self-checking bench for the periodic timer
`timescale 1ns/1ps
module tb_periodic_timer_modes;
   // ==========
   // signals
   reg         i_mclk = 1'b0;
   reg         i_arst_n = 1'b0;
   reg  [5:0]  awaddr = 6'h00, araddr = 6'h00;
   reg  [31:0] wdata = 32'h0;
   reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire        awready, wready, bvalid, arready, rvalid, tout, tout_en, fa, fp, cap, trig;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   reg  [31:0] seed = 32'h6fcef325, d, c1;
   reg  [1:0]  r;
   integer     n_mismatch = 0, check_count = 0, tmo = 0, cyc = 0;
   integer     na, np, nt, nh, la, lp, amin, amax, pmin, i, a, k, e, dd;
   reg         pout;
   integer     tp [0:5] = '{10, 10, 8, 10, 10, 10};
   integer     ta [0:5] = '{3, 3, 1, 12, 3, 3};
   integer     tc [0:5] = '{8'hA8, 8'hA1, 8'hAC, 8'hA8, 8'h80, 8'h98};
   integer     tv [0:5] = '{0, 0, 3, 0, 0, 0};
   initial forever #5 i_mclk = ~i_mclk;
   periodic_timer_modes dut (
      .i_mclk(i_mclk), .i_arst_n(i_arst_n),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_capture_input_pin(cap), .i_ext_trigger_pin(trig),
      .o_timer_out(tout), .o_timer_out_en(tout_en),
      .o_match_a_flag(fa), .o_match_p_flag(fp));
   ext_pin_model pins (.i_mclk(i_mclk), .o_cap(cap), .o_trig(trig));
   // ==========
   // monitor on the falling edge, where outputs have settled
   always @(negedge i_mclk) begin
      cyc = cyc + 1;
      if (fa === 1'b1) begin
         if (la >= 0 && cyc - la < amin) amin = cyc - la;
         if (la >= 0 && cyc - la > amax) amax = cyc - la;
         la = cyc;
         na = na + 1;
      end
      if (fp === 1'b1) begin
         if (lp >= 0 && cyc - lp < pmin) pmin = cyc - lp;
         lp = cyc;
         np = np + 1;
      end
      if (tout !== pout) nt = nt + 1;
      if (tout === 1'b1) nh = nh + 1;
      pout = tout;
   end
   // hang guard
   always @(posedge i_mclk) begin
      tmo = tmo + 1;
      if (tmo == 20000) begin
         n_mismatch = n_mismatch + 1;
         final_report;
      end
   end
   function [31:0] xs;
      input dummy;
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         xs = seed;
      end
   endfunction
   task clr;
      begin
         na = 0; np = 0; nt = 0; nh = 0; la = -1; lp = -1;
         amin = 99999; amax = 0; pmin = 99999; pout = tout;
      end
   endtask
   task chk(input [31:0] g, input [31:0] x);
      begin
         check_count = check_count + 1;
         if (g !== x) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %0h want %0h", $time, g, x);
         end
      end
   endtask
   task chk_in(input integer g, input integer lo, input integer hi);
      begin
         check_count = check_count + 1;
         if (g < lo || g > hi) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: %0d outside %0d..%0d", $time, g, lo, hi);
         end
      end
   endtask
   // bus master tasks: entered and left just after a rising edge
   task wr(input [5:0] ad, input [31:0] dt, output [1:0] rs);
      reg pa, pd;
      begin
         pa = 1'b1; pd = 1'b1;
         awaddr <= ad; wdata <= dt; awvalid <= 1'b1; wvalid <= 1'b1;
         while (pa || pd) begin
            @(posedge i_mclk);
            if (pa && awready) begin pa = 1'b0; awvalid <= 1'b0; end
            if (pd && wready) begin pd = 1'b0; wvalid <= 1'b0; end
         end
         // ready stands before the answer, so the answer is taken on the edge it is seen
         bready <= 1'b1;
         do @(posedge i_mclk); while (!bvalid);
         rs = bresp;
         bready <= 1'b0;
      end
   endtask
   task rd(input [5:0] ad, output [31:0] dt, output [1:0] rs);
      begin
         araddr <= ad; arvalid <= 1'b1;
         do @(posedge i_mclk); while (!arready);
         arvalid <= 1'b0;
         rready <= 1'b1;
         do @(posedge i_mclk); while (!rvalid);
         dt = rdata; rs = rresp;
         rready <= 1'b0;
      end
   endtask
   // load period, compare A and control b, then start the counter
   task go(input [9:0] p, input [9:0] ca, input [7:0] cb, input [7:0] dv);
      begin
         wr(6'h10, {22'h0, p}, r); wr(6'h0C, {22'h0, ca}, r); wr(6'h04, {24'h0, cb}, r);
         clr;
         wr(6'h00, {16'h0, dv, 8'h01}, r);
      end
   endtask
   task stop;
      begin wr(6'h00, 32'h0, r); repeat (4) @(posedge i_mclk); end
   endtask
   task final_report;
      begin
         $display("mismatches %0d, checks %0d", n_mismatch, check_count);
         if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   // ==========
   // main sequence
   initial begin
      repeat (8) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      @(posedge i_mclk);
      rd(6'h08, d, r); chk(d, 32'h0);
      wr(6'h0C, 32'h155, r); rd(6'h0C, d, r); chk(d, 32'h155);
      wr(6'h3C, 32'h1, r); chk(r, 2'h2);
      rd(6'h3C, d, r); chk(r, 2'h2);
      // compare mode: period or A clear, toggle or no action, zero period, mode 3
      go(10, 4, 8'h30, 0); repeat (100) @(posedge i_mclk); stop;
      chk(pmin, 10); chk(amin, 10); chk_in(na, 9, 12);
      chk(nt, na);
      go(10, 4, 8'h00, 0); stop; chk(tout, 0);
      go(10, 4, 8'h08, 0); repeat (50) @(posedge i_mclk); stop;
      chk(tout, 1); chk(nt, 1); chk_in(na, 4, 6);
      go(3, 6, 8'h31, 0); repeat (60) @(posedge i_mclk); stop;
      chk(amin, 6); chk(amax, 6); chk(np, 0);
      go(0, 0, 8'h30, 0); repeat (2100) @(posedge i_mclk); stop;
      chk(na, 0); chk(pmin, 1024); chk(nt, 0);
      go(10, 4, 8'hF0, 0); repeat (60) @(posedge i_mclk); chk(tout_en, 0); stop;
      chk(pmin, 10); chk(amin, 10);
      // pwm table, one entry drawn at random
      ta[2] = 1 + xs(0) % 7;
      for (i = 0; i < 6; i = i + 1) begin
         a = (ta[i] < tp[i]) ? ta[i] : tp[i];
         k = 5 * (tv[i] + 1);
         e = (tc[i][3] ? a : tp[i] - a) * k;
         if (tc[i][2]) e = tp[i] * k - e;
         if (tc[i][5:4] == 0) e = 0;
         if (tc[i][5:4] == 1) e = tp[i] * k;
         go(tp[i], ta[i], tc[i], tv[i]); repeat (40) @(posedge i_mclk); clr;
         repeat (tp[i] * k) @(posedge i_mclk);
         chk(nh, e);
         chk(np, 5);
         stop;
      end
      // single pulse from the trigger pin, software start and software stop
      wr(6'h0C, 32'd20, r); wr(6'h04, 32'hB0, r); clr;
      pins.pulse(1'b1, 3); repeat (40) @(posedge i_mclk);
      chk_in(nh, 19, 22); chk(na, 1);
      rd(6'h00, d, r); chk(d[0], 0);
      clr; wr(6'h00, 32'h1, r); repeat (40) @(posedge i_mclk);
      chk_in(nh, 19, 22); chk(na, 1);
      clr; wr(6'h00, 32'h1, r); repeat (5) @(posedge i_mclk); stop;
      chk_in(nh, 5, 15); chk(na, 0);
      // capture: spacing of two captured counts, edge codes, source select
      go(0, 0, 8'h40, 0); dd = 40 + (xs(0) & 63);
      fork
         pins.two(1'b0, 3, dd);
         begin repeat (10) @(posedge i_mclk); rd(6'h0C, c1, r); end
      join
      repeat (10) @(posedge i_mclk); rd(6'h0C, d, r);
      chk((d - c1) & 32'h3FF, dd); chk(na, 2);
      for (i = 0; i < 4; i = i + 1) begin
         wr(6'h04, 32'h40 | (i << 4), r); clr;
         pins.pulse(1'b0, 4); repeat (6) @(posedge i_mclk);
         chk(na, (i == 2) ? 2 : ((i == 3) ? 0 : 1));
      end
      wr(6'h04, 32'h42, r); clr; pins.pulse(1'b0, 4); repeat (6) @(posedge i_mclk);
      chk(na, 0); clr; pins.pulse(1'b1, 4); repeat (6) @(posedge i_mclk); chk(na, 1);
      wr(6'h10, 32'd50, r); clr; repeat (1200) @(posedge i_mclk); stop;
      chk(pmin, 50);
      final_report;
   end
endmodule // tb_periodic_timer_modes
bind periodic_timer_modes periodic_timer_modes_checker #(.CW(CW)) chk_i (.*);
